// >>> rbt_cfg.svh
// Constants of the registered bus transceiver
`ifndef RBT_CFG_SVH
`define RBT_CFG_SVH

// ==========================================================
// Widths and depths
`define RBT_WIDTH 16
`define RBT_HALF 8
`define RBT_FIFO_DEPTH 32
`define RBT_DIRS 2

// ==========================================================
// Control pin positions in the synchroniser vector
`define RBT_CTL_BITS 6
`define RBT_CTL_FWD_CLK 0
`define RBT_CTL_REV_CLK 1
`define RBT_CTL_FWD_CE_N 2
`define RBT_CTL_REV_CE_N 3
`define RBT_CTL_FWD_OE_N 4
`define RBT_CTL_REV_OE_N 5

// ==========================================================
// Reset values: clocks low, enables inactive (high)
`define RBT_CTL_RESET 6'h3C

`endif

// >>> rbt_pkg.sv
// Types of the registered bus transceiver
`include "rbt_cfg.svh"
package rbt_pkg;
    typedef logic [`RBT_WIDTH-1:0] rbt_word_t;
    typedef logic [`RBT_CTL_BITS-1:0] rbt_ctl_t;
endpackage : rbt_pkg

// >>> rbt_stream_if.sv
// Valid/ready word stream between transceiver modules
`timescale 1ns/1ps
interface rbt_stream_if #(
    parameter int W = 16
);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : rbt_stream_if

// >>> rbt_fifo.sv
// Word FIFO with registered read data
`timescale 1ns/1ps
module rbt_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 32
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    rbt_stream_if.snk wr,
    rbt_stream_if.src rd,
    output logic full_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [W-1:0] out_data_q;
    logic out_valid_q;
    logic push;
    logic pop;

    // ==========================================================
    // Handshakes
    assign wr.ready = (count_q != (AW+1)'(DEPTH));
    assign push = wr.valid && wr.ready;
    assign pop = (count_q != '0) && (!out_valid_q || rd.ready);
    assign rd.data = out_data_q;
    assign rd.valid = out_valid_q;

    // ==========================================================
    // Storage, no reset needed on the array
    always_ff @(posedge sys_clk_i)
    begin
        if (ce_i && push)
        begin
            mem[wr_ptr_q] <= wr.data;
        end
        if (ce_i && pop)
        begin
            out_data_q <= mem[rd_ptr_q];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            out_valid_q <= 1'b0;
            full_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
            full_o <= (count_q + (AW+1)'(push) - (AW+1)'(pop)) == (AW+1)'(DEPTH);
            if (pop)
            begin
                out_valid_q <= 1'b1;
            end
            else if (rd.ready)
            begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule : rbt_fifo

// >>> rbt_transceiver.sv
// Two-direction registered bus transceiver, 16 bits as two 8-bit halves
`timescale 1ns/1ps
`include "rbt_cfg.svh"
// Contract
// RL1 - With the forward clock enable low, a rising forward clock stores the A bus word; here a full queue drops the word instead.
// RL2 - Otherwise the forward register and the B output keep their earlier value.
// RL3 - With the forward output enable low, the forward register drives the B bus.
// RL4 - With the forward output enable high, the B drivers float whatever else happens.
// RL5 - The reverse path does the same from B to A with its own controls, independently.
// RL6 - The word is two 8-bit halves on shared controls, loading and enabling together.
// RL7 - The direction registers have no reset and read unknown until first loaded.
module rbt_transceiver
    import rbt_pkg::*;
#(
    parameter int W = `RBT_WIDTH,
    parameter int HALF = `RBT_HALF,
    parameter int DEPTH = `RBT_FIFO_DEPTH
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic drain_stall_i,
    input wire logic fwd_clock_i,
    input wire logic rev_clock_i,
    input wire logic fwd_clock_enable_n_i,
    input wire logic rev_clock_enable_n_i,
    input wire logic fwd_output_enable_n_i,
    input wire logic rev_output_enable_n_i,
    input wire logic [W-1:0] a_i,
    output logic [W-1:0] a_o,
    output logic [W-1:0] a_oe_o,
    input wire logic [W-1:0] b_i,
    output logic [W-1:0] b_o,
    output logic [W-1:0] b_oe_o,
    output logic fwd_full_o,
    output logic rev_full_o
);
    localparam int NHALF = W / HALF;

    rbt_ctl_t ctl_meta_q;
    rbt_ctl_t ctl_sync_q;
    logic [1:0] clk_prev_q;
    logic [W-1:0] a_meta_q;
    logic [W-1:0] a_sync_q;
    logic [W-1:0] b_meta_q;
    logic [W-1:0] b_sync_q;
    logic [1:0] cap_edge;
    logic [1:0] cap_ce_n;
    logic [1:0] full;
    rbt_word_t cap_word [2];
    rbt_word_t dir_q [2];

    // ==========================================================
    // Pin synchronisers, first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctl_meta_q <= `RBT_CTL_RESET;
            ctl_sync_q <= `RBT_CTL_RESET;
            clk_prev_q <= 2'h0;
        end
        else if (ce_i)
        begin
            ctl_meta_q <= {rev_output_enable_n_i, fwd_output_enable_n_i,
                           rev_clock_enable_n_i, fwd_clock_enable_n_i,
                           rev_clock_i, fwd_clock_i};
            ctl_sync_q <= ctl_meta_q;
            clk_prev_q <= {ctl_sync_q[`RBT_CTL_REV_CLK], ctl_sync_q[`RBT_CTL_FWD_CLK]};
        end
    end

    // Data rides alongside the clock so the captured word matches the edge
    always_ff @(posedge sys_clk_i)
    begin
        if (ce_i)
        begin
            a_meta_q <= a_i;
            a_sync_q <= a_meta_q;
            b_meta_q <= b_i;
            b_sync_q <= b_meta_q;
        end
    end

    // ==========================================================
    // Edge detection on the synchronised pin clocks
    assign cap_edge[0] = ctl_sync_q[`RBT_CTL_FWD_CLK] && !clk_prev_q[0];
    assign cap_edge[1] = ctl_sync_q[`RBT_CTL_REV_CLK] && !clk_prev_q[1];
    assign cap_ce_n[0] = ctl_sync_q[`RBT_CTL_FWD_CE_N];
    assign cap_ce_n[1] = ctl_sync_q[`RBT_CTL_REV_CE_N];
    assign cap_word[0] = a_sync_q;
    assign cap_word[1] = b_sync_q;

    // ==========================================================
    // One captured-word path per direction
    for (genvar d = 0; d < `RBT_DIRS; d++)
    begin : g_dir
        rbt_stream_if #(.W(W)) cap_if ();
        rbt_stream_if #(.W(W)) drn_if ();

        // A word is only offered on an enabled rising edge
        assign cap_if.valid = cap_edge[d] && !cap_ce_n[d]; // RL1 RL5
        assign cap_if.data = cap_word[d];
        // Stall lets words queue; a full queue drops the edge's word
        assign drn_if.ready = !drain_stall_i;

        rbt_fifo #(
            .W(W),
            .DEPTH(DEPTH)
        ) u_fifo (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .wr(cap_if),
            .rd(drn_if),
            .full_o(full[d])
        );

        // Halves share one load strobe so the word lands as a whole
        for (genvar h = 0; h < NHALF; h++)
        begin : g_half
            always_ff @(posedge sys_clk_i)
            begin
                if (ce_i && drn_if.valid && drn_if.ready) // RL1 RL2 RL6
                begin
                    dir_q[d][h*HALF +: HALF] <= drn_if.data[h*HALF +: HALF]; // RL7
                end
            end
        end
    end

    assign fwd_full_o = full[0];
    assign rev_full_o = full[1];

    // ==========================================================
    // Bus drivers: data untouched by reset, enables reset to float
    assign b_o = dir_q[0]; // RL3
    assign a_o = dir_q[1]; // RL5

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            b_oe_o <= '0;
            a_oe_o <= '0;
        end
        else if (ce_i)
        begin
            b_oe_o <= {W{!ctl_sync_q[`RBT_CTL_FWD_OE_N]}}; // RL3 RL4 RL6
            a_oe_o <= {W{!ctl_sync_q[`RBT_CTL_REV_OE_N]}}; // RL5
        end
    end
endmodule : rbt_transceiver

// >>> rbt_sva.sv
// Output checker of the registered bus transceiver
`timescale 1ns/1ps
module rbt_sva
    import rbt_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic drain_stall_i,
    input wire logic fwd_output_enable_n_i,
    input wire logic rev_output_enable_n_i,
    input wire logic [W-1:0] a_o,
    input wire logic [W-1:0] a_oe_o,
    input wire logic [W-1:0] b_o,
    input wire logic [W-1:0] b_oe_o,
    input wire logic fwd_full_o,
    input wire logic rev_full_o
);
    // ==========================================
    // Properties
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Three synchroniser edges, frozen while ce_i is low
    AST_FWD_OE: assert property ((rst_n_i && ce_i)[*4] |->
        b_oe_o == {W{!$past(fwd_output_enable_n_i, 3)}}) else $error("forward enable lags");
    AST_REV_OE: assert property ((rst_n_i && ce_i)[*4] |->
        a_oe_o == {W{!$past(rev_output_enable_n_i, 3)}}) else $error("reverse enable lags");
    AST_FWD_EQ: assert property (b_oe_o == '0 || b_oe_o == '1) else $error("B halves split");
    AST_REV_EQ: assert property (a_oe_o == '0 || a_oe_o == '1) else $error("A halves split");
    AST_FWD_HOLD: assert property (drain_stall_i[*2] |=> $stable(b_o)) else $error("B moved");
    AST_REV_HOLD: assert property (drain_stall_i[*2] |=> $stable(a_o)) else $error("A moved");
    AST_FWD_DRAIN: assert property (fwd_full_o && ce_i && !drain_stall_i |->
        ##[1:8] !fwd_full_o) else $error("forward queue stuck full");
    AST_REV_DRAIN: assert property (rev_full_o && ce_i && !drain_stall_i |->
        ##[1:8] !rev_full_o) else $error("reverse queue stuck full");
endmodule : rbt_sva

bind rbt_transceiver rbt_sva #(.W(W)) u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .drain_stall_i(drain_stall_i), .fwd_output_enable_n_i(fwd_output_enable_n_i),
    .rev_output_enable_n_i(rev_output_enable_n_i), .a_o(a_o), .a_oe_o(a_oe_o), .b_o(b_o),
    .b_oe_o(b_oe_o), .fwd_full_o(fwd_full_o), .rev_full_o(rev_full_o));

// >>> rbt_bus_model.sv
// Far-side bus: the device, else external driver, else a drifting float
`timescale 1ns/1ps
module rbt_bus_model
    import rbt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic ext_en_i,
    input wire rbt_word_t ext_d_i,
    input wire rbt_word_t dev_d_i,
    input wire rbt_word_t dev_oe_i,
    output rbt_word_t pin_o
);
    // ==========================================
    // Wire level
    rbt_word_t last_q;
    always_ff @(posedge sys_clk_i)
    begin
        last_q <= pin_o;
    end
    // No keeper: a floating bit flips so a stale value cannot pass
    assign pin_o = (dev_oe_i & dev_d_i) | (~dev_oe_i & (ext_en_i ? ext_d_i : ~last_q));
endmodule : rbt_bus_model

// >>> tb.sv
// Self-checking bench of the registered bus transceiver
`timescale 1ns/1ps
`include "rbt_cfg.svh"
module tb;
    import rbt_pkg::*;
    // ==========================================
    // Stimulus and checks
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, stall = 1'b0;
    logic fck = 1'b0, rck = 1'b0, fce_n = 1'b1, rce_n = 1'b1, foe_n = 1'b1, roe_n = 1'b1;
    logic fwd_full_o, rev_full_o;
    rbt_word_t a_i, a_o, a_oe_o, b_i, b_o, b_oe_o, a_ext = '0, b_ext = '0, w, f;
    int errors = 0, cmp_count = 0, cyc = 0;
    integer seed = 32'h9328CC13;
    always #2 sys_clk_i = ~sys_clk_i;
    rbt_transceiver uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .drain_stall_i(stall), .fwd_clock_i(fck), .rev_clock_i(rck),
        .fwd_clock_enable_n_i(fce_n), .rev_clock_enable_n_i(rce_n),
        .fwd_output_enable_n_i(foe_n), .rev_output_enable_n_i(roe_n), .a_i(a_i), .a_o(a_o),
        .a_oe_o(a_oe_o), .b_i(b_i), .b_o(b_o), .b_oe_o(b_oe_o), .fwd_full_o(fwd_full_o),
        .rev_full_o(rev_full_o));
    rbt_bus_model bus_a (.sys_clk_i(sys_clk_i), .ext_en_i(roe_n), .ext_d_i(a_ext),
        .dev_d_i(a_o), .dev_oe_i(a_oe_o), .pin_o(a_i));
    rbt_bus_model bus_b (.sys_clk_i(sys_clk_i), .ext_en_i(foe_n), .ext_d_i(b_ext),
        .dev_d_i(b_o), .dev_oe_i(b_oe_o), .pin_o(b_i));
    task automatic results();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    task automatic chk(input string nm, input rbt_word_t e, input rbt_word_t g);
        cmp_count++;
        if (e !== g)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : step
    // Pin clock held 4 cycles each level, above the 3-cycle minimum
    task automatic xfer(input bit rev, input rbt_word_t d);
        if (rev) b_ext = d; else a_ext = d;
        if (rev) rck = 1'b1; else fck = 1'b1;
        step(4);
        if (rev) rck = 1'b0; else fck = 1'b0;
        step(4);
    endtask : xfer
    // Register after one pin clock edge: kept while its enable is high
    function automatic rbt_word_t exp_load(input bit ce_n, input rbt_word_t old_w,
        input rbt_word_t new_w);
        return ce_n ? old_w : new_w;
    endfunction : exp_load
    // One word waits in the output stage, the queue holds DEPTH more, the rest drop
    function automatic rbt_word_t kept_last(input int sent);
        return rbt_word_t'((sent > `RBT_FIFO_DEPTH + 1) ? `RBT_FIFO_DEPTH : sent - 1);
    endfunction : kept_last
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            results();
        end
    end
    initial
    begin
        step(20);
        rst_n_i = 1'b1;
        chk("b_oe", '0, b_oe_o);
        fce_n = 1'b0;
        foe_n = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            f = rbt_word_t'($random(seed));
            xfer(1'b0, i == 0 ? 16'hFF00 : f);
            if (i == 0) f = 16'hFF00;
            chk("b_o", f, b_o);
            chk("b_pin", f, b_i);
            chk("b_oe", 16'hFFFF, b_oe_o);
        end
        chk("a_o", 16'hXXXX, a_o);
        fce_n = 1'b1;
        xfer(1'b0, ~f);
        chk("b_hold", exp_load(1'b1, f, ~f), b_o);
        fce_n = 1'b0;
        ce_i = 1'b0;
        xfer(1'b0, ~f);
        ce_i = 1'b1;
        step(6);
        chk("b_freeze", f, b_o);
        foe_n = 1'b1;
        roe_n = 1'b0;
        rce_n = 1'b0;
        step(4);
        chk("b_oe", '0, b_oe_o);
        for (int i = 0; i < 6; i++)
        begin
            w = rbt_word_t'($random(seed));
            xfer(1'b1, w);
            chk("a_o", w, a_o);
            chk("a_pin", w, a_i);
            chk("b_kept", f, b_o);
        end
        rce_n = 1'b1;
        xfer(1'b1, ~w);
        chk("a_hold", exp_load(1'b1, w, ~w), a_o);
        // Release bus A so the counted words reach the forward capture
        roe_n = 1'b1;
        step(4);
        stall = 1'b1;
        for (int i = 0; i < 34; i++)
            xfer(1'b0, rbt_word_t'(i));
        chk("full", 16'h0001, {15'h0000, fwd_full_o});
        stall = 1'b0;
        step(80);
        chk("full", '0, {14'h0000, fwd_full_o, rev_full_o});
        chk("b_drained", kept_last(34), b_o);
        foe_n = 1'b0;
        step(4);
        chk("b_oe", 16'hFFFF, b_oe_o);
        // Mid-run reset: enables float, the data register keeps its word
        rst_n_i = 1'b0;
        step(2);
        chk("b_oe_rst", '0, b_oe_o);
        chk("b_rst", kept_last(34), b_o);
        rst_n_i = 1'b1;
        xfer(1'b0, 16'h00FF);
        chk("b_o", 16'h00FF, b_o);
        chk("b_oe", 16'hFFFF, b_oe_o);
        results();
    end
endmodule : tb
